// File: core/cfpb_pkg.sv
// Shared constants and carrier types of the camera frame period and buffer registers.
package cfpb_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_PERIOD_CTRL  = 32'hf1000a00;
    localparam logic [31:0] ADDR_PERIOD_MIN   = 32'hf1000a04;
    localparam logic [31:0] ADDR_PERIOD_MAX   = 32'hf1000a08;
    localparam logic [31:0] ADDR_BUFFER_INFO  = 32'hf1000ffc;
    localparam logic [31:0] ADDR_WINDOW_FIRST = 32'hf1001000;
    localparam logic [31:0] ADDR_WINDOW_LAST  = 32'hf10017fc;
    localparam logic [31:0] ADDR_GAIN_CTRL    = 32'hf1002000;
    localparam logic [31:0] ADDR_GAIN_VALUE   = 32'hf1002004;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          PRESENCE_BIT      = 0;
    localparam int          PERIOD_ENABLE_BIT = 6;
    localparam int          PERIOD_LSB        = 8;
    localparam int          PERIOD_W          = 24;
    localparam int          GAIN_RELOAD_BIT   = 5;
    localparam int          WINDOW_SIZE_LSB   = 16;
    localparam int          WINDOW_WORDS      = 512;
    localparam int          WINDOW_ADDR_W     = 9;
    localparam logic [15:0] WINDOW_BYTES      = 16'h0800;
    localparam logic [23:0] PERIOD_MIN_US     = 24'h000064;
    localparam logic [23:0] PERIOD_MAX_US     = 24'hffffff;
    localparam logic [23:0] PERIOD_RESET_US   = 24'h000064;
    localparam logic [31:0] GAIN_RESET        = 32'h00000000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_PS     = 4000;
    localparam int          MICROSECOND_PS    = 1000000;
    localparam int          CYCLES_PER_US     = MICROSECOND_PS / CLK_PERIOD_PS;
    localparam logic [7:0]  US_DIV_LAST       = 8'(CYCLES_PER_US - 1);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cfpb_req_type;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [31:0] rdata;
    } cfpb_resp_type;

    typedef struct packed {
        logic [7:0] special;
        logic [7:0] major;
        logic [7:0] minor;
        logic [7:0] bugfix;
        logic       showSpecial;
    } cfpb_version_type;

endpackage

// File: core/cfpb_regs.sv
// Frame period control, shared data window and gain reference registers.
//
// Notes on behaviour
// - Control bits 31..8 hold the wanted frame period in microseconds.
// - Control bit 6 enables the programmed period; clear means it is ignored.
// - Bit 0 of both control registers reads one, marking the feature present.
// - Lower and upper period limits read at next words; writes are clamped.
// - Writing period control never alters exposure or packet payload settings.
// - Achieved frame rate is also limited by exposure time and packet size.
// - Transport speed follows only the packet payload size.
// - Buffer info bits 31..16 give window size in bytes; host reads first.
// - A shared data window spans its address range for table and image data.
// - Writing control bit 5 reloads the factory default gain reference.
// - The gain reference is a writable 32-bit word after its control register.
// - A changed gain reference is saved to nonvolatile store by itself.
// - Firmware version has special, major, minor, bugfix parts; zero special omitted.
`timescale 1ns/10ps
module cfpb_regs #(
    parameter logic [23:0] MIN_PERIOD_US = cfpb_pkg::PERIOD_MIN_US,
    parameter logic [23:0] MAX_PERIOD_US = cfpb_pkg::PERIOD_MAX_US,
    parameter logic [7:0]  VER_SPECIAL   = 8'h00,
    parameter logic [7:0]  VER_MAJOR     = 8'h01,
    parameter logic [7:0]  VER_MINOR     = 8'h00,
    parameter logic [7:0]  VER_BUGFIX    = 8'h00
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire cfpb_pkg::cfpb_req_type     busReq,
    output cfpb_pkg::cfpb_resp_type         busResp_q,
    input  wire logic [23:0]                exposureUs,
    input  wire logic [23:0]                packetFrameUs,
    input  wire logic [15:0]                packetPayloadSize,
    input  wire logic [31:0]                factoryGainRef,
    input  wire logic                       nvmRestoreValid,
    input  wire logic [31:0]                nvmRestoreValue,
    output logic                            frameStart_q,
    output logic [15:0]                     transportPayload_q,
    output logic [31:0]                     gainRef_q,
    output logic                            nvmStore_q,
    output logic [31:0]                     nvmStoreData_q,
    output cfpb_pkg::cfpb_version_type      version_q
);
    import cfpb_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic hitCtrl    = busReq.addr == ADDR_PERIOD_CTRL;
    wire logic hitMin     = busReq.addr == ADDR_PERIOD_MIN;
    wire logic hitMax     = busReq.addr == ADDR_PERIOD_MAX;
    wire logic hitInfo    = busReq.addr == ADDR_BUFFER_INFO;
    wire logic hitGainCtl = busReq.addr == ADDR_GAIN_CTRL;
    wire logic hitGainVal = busReq.addr == ADDR_GAIN_VALUE;
    wire logic hitWindow  = busReq.addr >= ADDR_WINDOW_FIRST
                          && busReq.addr <= ADDR_WINDOW_LAST
                          && busReq.addr[1:0] == 2'b00;
    wire logic hitAny     = hitCtrl
                          | hitMin | hitMax
                          | hitInfo
                          | hitGainCtl | hitGainVal
                          | hitWindow;
    wire logic wrStrobe   = busReq.valid & busReq.write;

    // ------------------------------------------------------------------
    // Frame period control
    // ------------------------------------------------------------------
    logic        periodEnable_q;
    logic [23:0] period_q;

    wire logic [23:0] wrPeriod     = busReq.wdata[PERIOD_LSB +: PERIOD_W];
    wire logic [23:0] clampedPeriod = wrPeriod < MIN_PERIOD_US ? MIN_PERIOD_US :
                                      wrPeriod > MAX_PERIOD_US ? MAX_PERIOD_US :
                                      wrPeriod;
    wire logic        wrCtrl       = wrStrobe & hitCtrl;

    // Only enable and period are stored; exposure and packet size live elsewhere.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            periodEnable_q <= 1'b0;
            period_q       <= PERIOD_RESET_US;
        end
        else if (wrCtrl)
        begin
            periodEnable_q <= busReq.wdata[PERIOD_ENABLE_BIT];
            period_q       <= clampedPeriod;
        end
    end

    // ------------------------------------------------------------------
    // Frame pacing
    // ------------------------------------------------------------------
    logic [7:0]  usDiv_q;
    logic [23:0] usCount_q;

    wire logic        usTick     = usDiv_q == US_DIV_LAST;
    wire logic [23:0] hwLimit    = exposureUs > packetFrameUs ? exposureUs : packetFrameUs;
    wire logic [23:0] progLimit  = periodEnable_q ? period_q : 24'h000001;
    wire logic [23:0] framePeriod = hwLimit > progLimit ? hwLimit : progLimit;
    wire logic        frameDue   = usTick && (usCount_q + 24'h000001) >= framePeriod;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            usDiv_q <= 8'h00;
        end
        else
        begin
            usDiv_q <= usTick ? 8'h00 : usDiv_q + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            frameStart_q <= 1'b0;
        end
        else
        begin
            frameStart_q <= frameDue;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            usCount_q <= 24'h000000;
        end
        else
        begin
            if (frameDue)
            begin
                usCount_q <= 24'h000000;
            end
            else if (usTick)
            begin
                usCount_q <= usCount_q + 24'h000001;
            end
        end
    end

    // The period register plays no part here, so speed cannot drift with it.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            transportPayload_q <= 16'h0000;
        end
        else
        begin
            transportPayload_q <= packetPayloadSize;
        end
    end

    // ------------------------------------------------------------------
    // Gain reference
    // ------------------------------------------------------------------
    wire logic wrGainVal  = wrStrobe & hitGainVal;
    wire logic wrReload   = wrStrobe & hitGainCtl & busReq.wdata[GAIN_RELOAD_BIT];
    wire logic gainChange = wrGainVal | wrReload;
    wire logic [31:0] gainNext = wrReload ? factoryGainRef : busReq.wdata;

    // A host write outranks a late restore so the newer value is kept.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gainRef_q <= GAIN_RESET;
        end
        else if (gainChange)
        begin
            gainRef_q <= gainNext;
        end
        else if (nvmRestoreValid)
        begin
            gainRef_q <= nvmRestoreValue;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nvmStore_q     <= 1'b0;
            nvmStoreData_q <= GAIN_RESET;
        end
        else
        begin
            nvmStore_q <= gainChange;
            if (gainChange)
            begin
                nvmStoreData_q <= gainNext;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared data window
    // ------------------------------------------------------------------
    logic [31:0] winRdata;

    cfpb_window_ram #(
        .WORDS  (WINDOW_WORDS),
        .ADDR_W (WINDOW_ADDR_W)
    ) u_window (
        .clk     (clk),
        .rst     (rst),
        .we      (wrStrobe & hitWindow),
        .addr    (busReq.addr[2 +: WINDOW_ADDR_W]),
        .wdata   (busReq.wdata),
        .rdata_q (winRdata)
    );

    // ------------------------------------------------------------------
    // Read data and response
    // ------------------------------------------------------------------
    wire logic [31:0] ctrlRead = {period_q, 1'b0, periodEnable_q, 5'b00000, 1'b1};
    wire logic [31:0] gainCtlRead = 32'h00000001;
    wire logic [31:0] infoRead = {WINDOW_BYTES, 16'h0000};
    wire logic [31:0] regRead  = hitCtrl    ? ctrlRead :
                                 hitMin     ? {8'h00, MIN_PERIOD_US} :
                                 hitMax     ? {8'h00, MAX_PERIOD_US} :
                                 hitInfo    ? infoRead :
                                 hitGainCtl ? gainCtlRead :
                                 hitGainVal ? gainRef_q :
                                 32'h00000000;

    logic        stageValid_q;
    logic        stageErr_q;
    logic        stageWin_q;
    logic [31:0] stageData_q;

    wire logic        reqRefused = busReq.valid & ~hitAny;
    wire logic        winRead    = busReq.valid & hitWindow & ~busReq.write;
    wire logic [31:0] stageNext  = busReq.write ? 32'h00000000 : regRead;

    // Two-cycle answer: the window memory needs one cycle before its word is ready.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stageValid_q <= 1'b0;
            stageErr_q   <= 1'b0;
        end
        else
        begin
            stageValid_q <= busReq.valid;
            stageErr_q   <= reqRefused;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stageWin_q  <= 1'b0;
            stageData_q <= 32'h00000000;
        end
        else
        begin
            stageWin_q  <= winRead;
            stageData_q <= stageNext;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busResp_q <= '0;
        end
        else
        begin
            busResp_q.valid <= stageValid_q;
            busResp_q.err   <= stageValid_q & stageErr_q;
            busResp_q.rdata <= stageWin_q ? winRdata : stageData_q;
        end
    end

    // ------------------------------------------------------------------
    // Version
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            version_q <= '0;
        end
        else
        begin
            version_q.special     <= VER_SPECIAL;
            version_q.major       <= VER_MAJOR;
            version_q.minor       <= VER_MINOR;
            version_q.bugfix      <= VER_BUGFIX;
            version_q.showSpecial <= VER_SPECIAL != 8'h00;
        end
    end

endmodule

// File: core/cfpb_window_ram.sv
// Word-wide storage behind the shared data window.
`timescale 1ns/10ps
module cfpb_window_ram #(
    parameter int WORDS  = 512,
    parameter int ADDR_W = 9
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    output logic      [31:0]       rdata_q
);

    logic [31:0] mem [WORDS];

    // Storage is left uninitialised to keep it a plain block memory.
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_q <= 32'h00000000;
        end
        else
        begin
            rdata_q <= mem[addr];
        end
    end

endmodule

// File: sim/cfpb_host.sv
// Host software model issuing single quadlet accesses.
`timescale 1ns/10ps
module cfpb_host (
    input wire logic                    clk,
    output cfpb_pkg::cfpb_req_type      busReq,
    input wire cfpb_pkg::cfpb_resp_type busResp
);
    import cfpb_pkg::*;
    // Table data is little endian locally, so each quadlet is swapped first.
    function automatic logic [31:0] toBus(input logic [31:0] le);
        return {le[7:0], le[15:8], le[23:16], le[31:24]};
    endfunction
    initial busReq = '0;
    // One function at a time, one quadlet each: block transfers are not modelled.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        busReq <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge clk);
        // Released lines show garbage so stale values are never trusted.
        busReq <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (!busResp.valid && n < 4);
        if (!busResp.valid)
        begin
            cfpb_regs_tb.err_total++;
            cfpb_regs_tb.tally_and_finish();
        end
        r = busResp.rdata;
        e = busResp.err;
    endtask
endmodule

// File: sim/cfpb_regs_chk.sv
// Assertion checker bound to the frame period and buffer registers.
`timescale 1ns/10ps
module cfpb_regs_chk #(
    parameter logic [23:0] MIN_PERIOD_US = cfpb_pkg::PERIOD_MIN_US
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire cfpb_pkg::cfpb_req_type     busReq,
    input wire cfpb_pkg::cfpb_resp_type    busResp_q,
    input wire logic [15:0]                packetPayloadSize,
    input wire logic [31:0]                factoryGainRef,
    input wire logic                       frameStart_q,
    input wire logic [15:0]                transportPayload_q,
    input wire logic [31:0]                gainRef_q,
    input wire logic                       nvmStore_q,
    input wire logic [31:0]                nvmStoreData_q,
    input wire cfpb_pkg::cfpb_version_type version_q
);
    import cfpb_pkg::*;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    wire rdReq = busReq.valid && !busReq.write;
    wire wrReq = busReq.valid && busReq.write;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    resp_latency_a: assert property (busReq.valid |-> ##2 busResp_q.valid)
        else $error("answer latency wrong");
    ctrl_bits_a: assert property (rdReq && busReq.addr == ADDR_PERIOD_CTRL
        |-> ##2 busResp_q.rdata[7:0] inside {8'h01, 8'h41}) else $error("control low bits");
    min_limit_a: assert property (rdReq && busReq.addr == ADDR_PERIOD_MIN
        |-> ##2 busResp_q.rdata == {8'h00, MIN_PERIOD_US}) else $error("lower limit");
    period_clamp_a: assert property (rdReq && busReq.addr == ADDR_PERIOD_CTRL
        |-> ##2 busResp_q.rdata[31:8] >= MIN_PERIOD_US) else $error("period below limit");
    buf_size_a: assert property (rdReq && busReq.addr == ADDR_BUFFER_INFO
        |-> ##2 busResp_q.rdata == {WINDOW_BYTES, 16'h0000}) else $error("window size");
    gain_ctrl_a: assert property (rdReq && busReq.addr == ADDR_GAIN_CTRL
        |-> ##2 busResp_q.rdata == 32'h00000001) else $error("gain control read");
    gain_store_a: assert property (wrReq && busReq.addr == ADDR_GAIN_VALUE |=>
        gainRef_q == $past(busReq.wdata) && nvmStore_q && nvmStoreData_q == gainRef_q)
        else $error("gain save");
    gain_reload_a: assert property (wrReq && busReq.addr == ADDR_GAIN_CTRL
        && busReq.wdata[GAIN_RELOAD_BIT] |=> gainRef_q == $past(factoryGainRef))
        else $error("gain reload");
    transport_a: assert property (!$past(rst) |->
        transportPayload_q == $past(packetPayloadSize)) else $error("transport payload");
    frame_pulse_a: assert property (frameStart_q |=> !frameStart_q [*8])
        else $error("frame pulse too close");
    version_flag_a: assert property (version_q.showSpecial == (version_q.special != 8'h00))
        else $error("special flag");
    cover property (wrReq && busReq.addr == ADDR_GAIN_VALUE);
    cover property (frameStart_q);
    cover property (busResp_q.valid && busResp_q.err);
endmodule
bind cfpb_regs cfpb_regs_chk #(.MIN_PERIOD_US(MIN_PERIOD_US)) chk (
    .clk(clk), .rst(rst), .busReq(busReq), .busResp_q(busResp_q),
    .packetPayloadSize(packetPayloadSize), .factoryGainRef(factoryGainRef),
    .frameStart_q(frameStart_q), .transportPayload_q(transportPayload_q),
    .gainRef_q(gainRef_q), .nvmStore_q(nvmStore_q), .nvmStoreData_q(nvmStoreData_q),
    .version_q(version_q));

// File: sim/cfpb_regs_tb.sv
// Self-checking testbench of the frame period and buffer registers.
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module cfpb_regs_tb;
    import cfpb_pkg::*;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    cfpb_req_type            busReq;
    cfpb_resp_type           busResp_q;
    logic [23:0]             exposureUs = '0;
    logic [23:0]             packetFrameUs = '0;
    logic [15:0]             packetPayloadSize = 16'h0400;
    logic [31:0]             factoryGainRef = 32'h000000c3;
    logic                    nvmRestoreValid = 1'b0;
    logic [31:0]             nvmRestoreValue = '0;
    logic                    frameStart_q, nvmStore_q;
    logic [15:0]             transportPayload_q;
    logic [31:0]             gainRef_q, nvmStoreData_q, rdData;
    logic                    rdErr;
    cfpb_version_type        version_q;
    int                      err_total = 0;
    int                      checked = 0;
    always #2 clk = ~clk;
    cfpb_host host (.clk(clk), .busReq(busReq), .busResp(busResp_q));
    // A lower limit of 2 us keeps frame periods short enough to measure.
    cfpb_regs #(.MIN_PERIOD_US(24'h000002), .VER_SPECIAL(8'h07)) uut (
        .clk(clk), .rst(rst), .busReq(busReq), .busResp_q(busResp_q),
        .exposureUs(exposureUs), .packetFrameUs(packetFrameUs),
        .packetPayloadSize(packetPayloadSize), .factoryGainRef(factoryGainRef),
        .nvmRestoreValid(nvmRestoreValid), .nvmRestoreValue(nvmRestoreValue),
        .frameStart_q(frameStart_q), .transportPayload_q(transportPayload_q),
        .gainRef_q(gainRef_q), .nvmStore_q(nvmStore_q), .nvmStoreData_q(nvmStoreData_q),
        .version_q(version_q));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rdData, rdErr);
        `CHK(rdData, exp)
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdData, rdErr);
    endtask
    // The first two waits only align to a frame; the third is the measured gap.
    task automatic gap(input int exp);
        int n;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end
            while (!frameStart_q && n < 3000);
            if (!frameStart_q)
            begin
                err_total++;
                tally_and_finish();
            end
        end
        `CHK(n, exp)
    endtask
    task automatic t_reset();
        rd(ADDR_PERIOD_CTRL, {PERIOD_RESET_US, 8'h01});
        rd(ADDR_PERIOD_MIN, 32'h00000002);
        rd(ADDR_PERIOD_MAX, {8'h00, PERIOD_MAX_US});
        rd(ADDR_GAIN_CTRL, 32'h00000001);
        rd(ADDR_GAIN_VALUE, GAIN_RESET);
        `CHK(version_q, {8'h07, 8'h01, 8'h00, 8'h00, 1'b1})
    endtask
    task automatic t_period();
        wr(ADDR_PERIOD_CTRL, 32'h000001fe);
        rd(ADDR_PERIOD_CTRL, 32'h00000241);
        wr(ADDR_PERIOD_CTRL, 32'h000003fe);
        rd(ADDR_PERIOD_CTRL, 32'h00000341);
        wr(ADDR_PERIOD_MIN, 32'h0);
        rd(ADDR_PERIOD_MIN, 32'h00000002);
        `CHK(transportPayload_q, 16'h0400)
        @(posedge clk);
        packetPayloadSize <= 16'h0200;
        repeat (2) @(negedge clk);
        `CHK(transportPayload_q, 16'h0200)
    endtask
    task automatic t_pacing();
        gap(750);
        @(posedge clk);
        exposureUs <= 24'd5;
        gap(1250);
        @(posedge clk);
        exposureUs <= 24'd0;
        packetFrameUs <= 24'd4;
        gap(1000);
        @(posedge clk);
        packetFrameUs <= 24'd0;
        wr(ADDR_PERIOD_CTRL, 32'h00000301);
        gap(250);
    endtask
    task automatic t_window();
        rd(ADDR_BUFFER_INFO, 32'h08000000);
        wr(ADDR_WINDOW_FIRST, host.toBus(32'h03020100));
        wr(ADDR_WINDOW_LAST, host.toBus(32'hccddeeff));
        rd(ADDR_WINDOW_FIRST, 32'h00010203);
        rd(ADDR_WINDOW_LAST, 32'hffeeddcc);
        `CHK(rdErr, 1'b0)
        rd(32'hf1001002, 32'h0);
        `CHK(rdErr, 1'b1)
        wr(32'hf1000a0c, 32'h5);
        `CHK(rdErr, 1'b1)
    endtask
    task automatic t_gain();
        wr(ADDR_GAIN_VALUE, 32'h000001a5);
        `CHK(gainRef_q, 32'h000001a5)
        `CHK(nvmStoreData_q, 32'h000001a5)
        rd(ADDR_GAIN_VALUE, 32'h000001a5);
        wr(ADDR_GAIN_CTRL, 32'h00000020);
        `CHK(gainRef_q, 32'h000000c3)
        rd(ADDR_GAIN_CTRL, 32'h00000001);
        @(posedge clk);
        nvmRestoreValid <= 1'b1;
        nvmRestoreValue <= 32'h00000077;
        @(posedge clk);
        nvmRestoreValid <= 1'b0;
        @(negedge clk);
        `CHK(gainRef_q, 32'h00000077)
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_period();
        t_pacing();
        t_window();
        t_gain();
        tally_and_finish();
    end
endmodule
